// [include/tx_buffer_pkg.sv]
package tx_buffer_pkg;

    // ------------------------------------------------------------
    // memory geometry
    // ------------------------------------------------------------
    localparam int MEM_ADDR_WIDTH = 6;      // address bits, one wrap bit is added on top
    localparam int PTR_WIDTH      = MEM_ADDR_WIDTH + 1;
    localparam int WORD_WIDTH     = 32;     // frame word from the input fifo

    // ------------------------------------------------------------
    // staging buffer between input fifo and memory
    // ------------------------------------------------------------
    localparam int BUF_DEPTH      = 8;
    localparam int BUF_LEVEL_W    = $clog2(BUF_DEPTH + 1);

    // ------------------------------------------------------------
    // reset values and the pointer increment
    // ------------------------------------------------------------
    localparam logic [PTR_WIDTH-1:0]  PTR_RESET   = 7'h00;
    localparam logic [WORD_WIDTH-1:0] WORD_RESET  = 32'h0000_0000;
    localparam logic [PTR_WIDTH-1:0]  PTR_ONE     = 7'h01;

    // forwarding_mode_select level that means store-and-forward
    localparam logic STORE_FORWARD = 1'h1;

    // ------------------------------------------------------------
    // splitter states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        IDLE_STATE             = 5'h01,
        PAYLOAD_READ_STATE     = 5'h02,
        PAUSE_FRAME_READ_STATE = 5'h04,
        DISCARD_STATE          = 5'h08,
        HOLD_STATE             = 5'h10
    } split_state_type;

endpackage

// [src/wrap_full_detect.sv]
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// full compare of a wrapped pointer against the read address
// ------------------------------------------------------------
module wrap_full_detect #(
    parameter int ADDR_WIDTH = 6
) (
    input  wire logic [ADDR_WIDTH:0] write_ptr,   // pointer with wrap bit on top
    input  wire logic [ADDR_WIDTH:0] read_ptr,    // read address with wrap bit
    output logic                     full         // memory is full
);

    // wrap bits differ while the address bits meet: one lap ahead
    assign full = (write_ptr[ADDR_WIDTH] != read_ptr[ADDR_WIDTH]) &&
                  (write_ptr[ADDR_WIDTH-1:0] == read_ptr[ADDR_WIDTH-1:0]);

endmodule

`default_nettype wire

// [src/stage_fifo.sv]
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// small synchronous fifo in flip-flops
// ------------------------------------------------------------
module stage_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic                       clk,        // clock
    input  wire logic                       rst_n,      // async reset, active low
    input  wire logic                       in_valid,   // push request
    output logic                            in_ready,   // room for a word
    input  wire logic [WIDTH-1:0]           in_data,    // pushed word
    output logic                            out_valid,  // word available
    input  wire logic                       out_ready,  // pop request
    output logic [WIDTH-1:0]                out_data,   // head word
    output logic [$clog2(DEPTH+1)-1:0]      level       // words held
);

    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] store_reg [DEPTH];
    logic [AW-1:0]    wr_idx_reg;
    logic [AW-1:0]    rd_idx_reg;
    logic [LW-1:0]    level_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // flags straight from the count, so full and empty are exact
    assign in_ready  = (level_reg != LW'(DEPTH));
    assign out_valid = (level_reg != '0);
    assign out_data  = store_reg[rd_idx_reg];
    assign level     = level_reg;

    // index and count bookkeeping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_idx_reg <= '0;
            rd_idx_reg <= '0;
            level_reg  <= '0;
        end else begin
            if (push) begin
                wr_idx_reg <= (wr_idx_reg == AW'(DEPTH - 1)) ? '0 : wr_idx_reg + 1'b1;
            end
            if (pop) begin
                rd_idx_reg <= (rd_idx_reg == AW'(DEPTH - 1)) ? '0 : rd_idx_reg + 1'b1;
            end
            if (push && !pop) begin
                level_reg <= level_reg + 1'b1;
            end else if (pop && !push) begin
                level_reg <= level_reg - 1'b1;
            end
        end
    end

    // storage has no reset, data only
    always_ff @(posedge clk) begin
        if (push) begin
            store_reg[wr_idx_reg] <= in_data;
        end
    end

endmodule

`default_nettype wire

// [src/tx_buffer_write_and_split_control.sv]
// Operation
// - async low reset clears splitter and writer
// - idle: reload goes to hold first
// - idle: pause grant enters pause read
// - idle: payload grant enters payload read
// - payload read: remove, reload, end+read hold
// - pause read: remove, reload, end+read discard
// - discard: pause grant wins, enter pause read
// - discard: reload pending goes to hold
// - discard: valid locked word holds, unlocked start idles
// - hold: back to discard once reload drops
// - move input fifo words into memory
// - keep write pointer and published address
// - publish above threshold or frame stored
// - address width six, pointers carry wrap
// - full from pointer and incremented pointer
// - no read while empty, enables one process
// - runs on free transmit clock
`timescale 1ns/10ps
`default_nettype none

module tx_buffer_write_and_split_control (
    input  wire logic                                    FREE_TX_CLOCK,           // free transmit clock
    input  wire logic                                    GLOBAL_RESET_N,          // async reset, active low
    // input fifo side
    input  wire logic                                    INPUT_FIFO_EMPTY,        // input fifo has no word
    input  wire logic [tx_buffer_pkg::WORD_WIDTH-1:0]    INPUT_FIFO_DATA,         // word, cycle after read
    output logic                                         INPUT_FIFO_READ_ENABLE,  // pop input fifo
    // memory side
    output logic                                         MEMORY_WRITE_ENABLE,     // write strobe
    output logic [tx_buffer_pkg::WORD_WIDTH-1:0]         MEMORY_WRITE_DATA,       // written word
    output logic [tx_buffer_pkg::PTR_WIDTH-1:0]          MEMORY_WRITE_POINTER,    // write address plus wrap
    output logic [tx_buffer_pkg::PTR_WIDTH-1:0]          PUBLISHED_WRITE_ADDRESS, // address seen by tx fsm
    output logic                                         MEMORY_FULL,             // memory full flag
    input  wire logic [tx_buffer_pkg::PTR_WIDTH-1:0]     MEMORY_READ_ADDRESS,     // read address plus wrap
    // configuration
    input  wire logic                                    FORWARDING_MODE_SELECT,  // high: store-and-forward
    input  wire logic [tx_buffer_pkg::MEM_ADDR_WIDTH-1:0] CUT_THROUGH_LEVEL,      // cut-through threshold
    input  wire logic                                    FRAME_STORED_FLAG,       // frame end now in memory
    // splitter side
    input  wire logic                                    PAUSE_FRAME_GRANT,       // pause frame acknowledge
    input  wire logic                                    PAYLOAD_FRAME_GRANT,     // data frame acknowledge
    input  wire logic                                    RELOAD_FRAME,            // retransmit current frame
    input  wire logic                                    REMOVE_FRAME,            // drop current frame
    input  wire logic                                    NEXT_WORD_REQUEST,       // read next data
    input  wire logic                                    FRAME_END_OUT,           // end word is on output
    input  wire logic                                    VALID_DATA,              // buffered word valid
    input  wire logic                                    FRAME_START_IN,          // word starts a frame
    input  wire logic                                    UNLOCK_START,            // start is unlocked
    output logic [4:0]                                   SPLIT_STATE              // one-hot splitter state
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam int PW = tx_buffer_pkg::PTR_WIDTH;
    localparam int LW = tx_buffer_pkg::BUF_LEVEL_W;

    tx_buffer_pkg::split_state_type split_reg;
    tx_buffer_pkg::split_state_type split_next;

    logic          rd_en_reg;
    logic          rd_en_next;
    logic          rd_en_d_reg;
    logic          wr_en_reg;
    logic          wr_en_next;
    logic [tx_buffer_pkg::WORD_WIDTH-1:0] wr_data_reg;
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] pub_addr_reg;
    logic [PW-1:0] pub_addr_next;
    logic [PW-1:0] frame_words_reg;
    logic [PW-1:0] frame_words_next;
    logic          full_reg;

    wire  [PW-1:0] wr_inc;
    wire           full_now;
    wire           full_inc;
    wire           mem_blocked;
    wire           buf_in_ready;
    wire           buf_out_valid;
    wire  [tx_buffer_pkg::WORD_WIDTH-1:0] buf_out_data;
    wire  [LW-1:0] buf_level;
    wire  [LW:0]   committed;
    wire           room;
    wire           pop;
    wire           over_level;
    wire           cut_through_ok;
    wire           counting_max;

    // ------------------------------------------------------------
    // full detection
    // ------------------------------------------------------------
    assign wr_inc = wr_ptr_reg + tx_buffer_pkg::PTR_ONE;

    // current pointer against read address
    wrap_full_detect #(
        .ADDR_WIDTH (tx_buffer_pkg::MEM_ADDR_WIDTH)
    ) full_cur (
        .write_ptr (wr_ptr_reg),
        .read_ptr  (MEMORY_READ_ADDRESS),
        .full      (full_now)
    );

    // pointer after the write now in flight
    wrap_full_detect #(
        .ADDR_WIDTH (tx_buffer_pkg::MEM_ADDR_WIDTH)
    ) full_nxt (
        .write_ptr (wr_inc),
        .read_ptr  (MEMORY_READ_ADDRESS),
        .full      (full_inc)
    );

    // a write in flight still takes a slot, so look one ahead then
    assign mem_blocked = full_now || (wr_en_reg && full_inc);

    // ------------------------------------------------------------
    // staging buffer
    // ------------------------------------------------------------
    // reads in flight count as committed; empty lags a pop, so reads alternate
    assign committed  = {1'b0, buf_level} + {{LW{1'b0}}, rd_en_reg} + {{LW{1'b0}}, rd_en_d_reg};
    assign room       = (committed < (LW+1)'(tx_buffer_pkg::BUF_DEPTH));
    assign rd_en_next = !INPUT_FIFO_EMPTY && room && !rd_en_reg;
    assign pop        = buf_out_valid && !mem_blocked;
    assign wr_en_next = pop;

    stage_fifo #(
        .WIDTH (tx_buffer_pkg::WORD_WIDTH),
        .DEPTH (tx_buffer_pkg::BUF_DEPTH)
    ) stage (
        .clk       (FREE_TX_CLOCK),
        .rst_n     (GLOBAL_RESET_N),
        .in_valid  (rd_en_d_reg),
        .in_ready  (buf_in_ready),
        .in_data   (INPUT_FIFO_DATA),
        .out_valid (buf_out_valid),
        .out_ready (!mem_blocked),
        .out_data  (buf_out_data),
        .level     (buf_level)
    );

    // read enable and memory write enable share one process
    always_ff @(posedge FREE_TX_CLOCK or negedge GLOBAL_RESET_N) begin
        if (!GLOBAL_RESET_N) begin
            rd_en_reg   <= 1'b0;
            rd_en_d_reg <= 1'b0;
            wr_en_reg   <= 1'b0;
            wr_data_reg <= tx_buffer_pkg::WORD_RESET;
        end else begin
            rd_en_reg   <= rd_en_next && buf_in_ready;
            rd_en_d_reg <= rd_en_reg;
            wr_en_reg   <= wr_en_next;
            wr_data_reg <= pop ? buf_out_data : wr_data_reg;
        end
    end

    // ------------------------------------------------------------
    // write pointer, frame word count, published address
    // ------------------------------------------------------------
    // count saturates so a long frame cannot wrap below the threshold
    assign counting_max   = (frame_words_reg == {PW{1'b1}});
    assign over_level     = (frame_words_reg > {1'b0, CUT_THROUGH_LEVEL});
    // store-and-forward waits for the whole frame
    assign cut_through_ok = (FORWARDING_MODE_SELECT != tx_buffer_pkg::STORE_FORWARD) && over_level;

    // publish on a stored frame end or on cut-through past the level
    assign pub_addr_next = (FRAME_STORED_FLAG || cut_through_ok) ? wr_ptr_reg : pub_addr_reg;

    assign frame_words_next = FRAME_STORED_FLAG ? tx_buffer_pkg::PTR_RESET :
                              (wr_en_reg && !counting_max) ? frame_words_reg + tx_buffer_pkg::PTR_ONE :
                              frame_words_reg;

    // pointer moves on the edge that completes a write
    always_ff @(posedge FREE_TX_CLOCK or negedge GLOBAL_RESET_N) begin
        if (!GLOBAL_RESET_N) begin
            wr_ptr_reg      <= tx_buffer_pkg::PTR_RESET;
            pub_addr_reg    <= tx_buffer_pkg::PTR_RESET;
            frame_words_reg <= tx_buffer_pkg::PTR_RESET;
            full_reg        <= 1'b0;
        end else begin
            wr_ptr_reg      <= wr_en_reg ? wr_inc : wr_ptr_reg;
            pub_addr_reg    <= pub_addr_next;
            frame_words_reg <= frame_words_next;
            full_reg        <= mem_blocked;
        end
    end

    // ------------------------------------------------------------
    // splitter state machine
    // ------------------------------------------------------------
    always_comb begin
        split_next = split_reg;
        case (split_reg)
            tx_buffer_pkg::IDLE_STATE: begin
                if (RELOAD_FRAME) begin
                    split_next = tx_buffer_pkg::HOLD_STATE;
                end else if (PAUSE_FRAME_GRANT) begin
                    split_next = tx_buffer_pkg::PAUSE_FRAME_READ_STATE;
                end else if (PAYLOAD_FRAME_GRANT) begin
                    split_next = tx_buffer_pkg::PAYLOAD_READ_STATE;
                end
            end
            tx_buffer_pkg::PAYLOAD_READ_STATE: begin
                // end word leaves whether or not the buffered word is valid
                if (REMOVE_FRAME || RELOAD_FRAME || (FRAME_END_OUT && NEXT_WORD_REQUEST)) begin
                    split_next = tx_buffer_pkg::HOLD_STATE;
                end
            end
            tx_buffer_pkg::PAUSE_FRAME_READ_STATE: begin
                if (REMOVE_FRAME || RELOAD_FRAME || (FRAME_END_OUT && NEXT_WORD_REQUEST)) begin
                    split_next = tx_buffer_pkg::DISCARD_STATE;
                end
            end
            tx_buffer_pkg::DISCARD_STATE: begin
                if (PAUSE_FRAME_GRANT) begin
                    split_next = tx_buffer_pkg::PAUSE_FRAME_READ_STATE;
                end else if (RELOAD_FRAME) begin
                    split_next = tx_buffer_pkg::HOLD_STATE;
                end else if (VALID_DATA && (!FRAME_START_IN || !UNLOCK_START)) begin
                    split_next = tx_buffer_pkg::HOLD_STATE;
                end else if (VALID_DATA && FRAME_START_IN && UNLOCK_START) begin
                    split_next = tx_buffer_pkg::IDLE_STATE;
                end
            end
            tx_buffer_pkg::HOLD_STATE: begin
                if (!RELOAD_FRAME) begin
                    split_next = tx_buffer_pkg::DISCARD_STATE;
                end
            end
            default: begin
                split_next = tx_buffer_pkg::IDLE_STATE;
            end
        endcase
    end

    // state register
    always_ff @(posedge FREE_TX_CLOCK or negedge GLOBAL_RESET_N) begin
        if (!GLOBAL_RESET_N) begin
            split_reg <= tx_buffer_pkg::IDLE_STATE;
        end else begin
            split_reg <= split_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------
    assign INPUT_FIFO_READ_ENABLE  = rd_en_reg;
    assign MEMORY_WRITE_ENABLE     = wr_en_reg;
    assign MEMORY_WRITE_DATA       = wr_data_reg;
    assign MEMORY_WRITE_POINTER    = wr_ptr_reg;
    assign PUBLISHED_WRITE_ADDRESS = pub_addr_reg;
    assign MEMORY_FULL             = full_reg;
    assign SPLIT_STATE             = split_reg;

endmodule

`default_nettype wire

// [verif/input_fifo_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// input fifo seen from the block: one-cycle read latency
// ------------------------------------------------------------
module input_fifo_model #(
    parameter logic [31:0] WORD_BASE = 32'hA500_0000 // first word, arbitrary pattern
) (
    input  wire logic        clk,         // transmit clock
    input  wire logic        rst_n,       // async reset, active low
    input  wire logic        read_enable, // pop from the block
    input  wire logic [7:0]  add_words,   // words queued by the bench
    output logic             empty,       // no word held
    output logic [31:0]      data         // word, cycle after a pop
);
    logic [7:0]  count_reg;
    logic [31:0] seq_reg;
    logic        pop;

    // a pop on empty is ignored
    assign pop   = read_enable && (count_reg != 8'h00);
    assign empty = (count_reg == 8'h00);

    // data toggles between pops so stale words show
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 8'h00;
            seq_reg   <= WORD_BASE;
            data      <= ~WORD_BASE;
        end else begin
            count_reg <= count_reg + add_words - {7'h00, pop};
            if (pop) begin
                data    <= seq_reg;
                seq_reg <= seq_reg + 32'h0000_0001;
            end else begin
                data <= ~data;
            end
        end
    end
endmodule

`default_nettype wire

// [verif/tx_buffer_write_and_split_control_properties.sv]
`timescale 1ns/10ps
`default_nettype none

module tx_buffer_write_and_split_control_properties #(
    parameter int PW = tx_buffer_pkg::PTR_WIDTH
) (
    input  wire logic          FREE_TX_CLOCK,           // clock
    input  wire logic          GLOBAL_RESET_N,          // reset, low
    input  wire logic          INPUT_FIFO_EMPTY,        // fifo empty
    input  wire logic          INPUT_FIFO_READ_ENABLE,  // pop
    input  wire logic          MEMORY_WRITE_ENABLE,     // write
    input  wire logic [PW-1:0] MEMORY_WRITE_POINTER,    // pointer
    input  wire logic [PW-1:0] PUBLISHED_WRITE_ADDRESS, // published
    input  wire logic [PW-1:0] MEMORY_READ_ADDRESS,     // read address
    input  wire logic          FORWARDING_MODE_SELECT,  // mode
    input  wire logic          FRAME_STORED_FLAG,       // stored
    input  wire logic          PAUSE_FRAME_GRANT,       // pause grant
    input  wire logic          RELOAD_FRAME,            // reload
    input  wire logic [4:0]    SPLIT_STATE              // state
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    wire full_now = (MEMORY_WRITE_POINTER[6] != MEMORY_READ_ADDRESS[6])
                    && (MEMORY_WRITE_POINTER[5:0] == MEMORY_READ_ADDRESS[5:0]);
    wire idle_now = (SPLIT_STATE == tx_buffer_pkg::IDLE_STATE);

    default clocking cb @(posedge FREE_TX_CLOCK); endclocking
    default disable iff (!GLOBAL_RESET_N);

    property p_no_pop_empty;
        INPUT_FIFO_READ_ENABLE |-> !$past(INPUT_FIFO_EMPTY);
    endproperty
    a_no_pop_empty: assert property (p_no_pop_empty) else $error("pop while input fifo empty");

    property p_ptr_step;
        MEMORY_WRITE_ENABLE |=> MEMORY_WRITE_POINTER == $past(MEMORY_WRITE_POINTER) + tx_buffer_pkg::PTR_ONE;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer step");

    property p_no_write_full;
        full_now |-> !MEMORY_WRITE_ENABLE;
    endproperty
    a_no_write_full: assert property (p_no_write_full) else $error("write into full memory");

    property p_publish_stored;
        FRAME_STORED_FLAG |=> PUBLISHED_WRITE_ADDRESS == $past(MEMORY_WRITE_POINTER);
    endproperty
    a_publish_stored: assert property (p_publish_stored) else $error("stored frame not published");

    // in store-and-forward only a stored frame may move the published address
    property p_publish_cause;
        !$stable(PUBLISHED_WRITE_ADDRESS) |-> $past(FRAME_STORED_FLAG) || !$past(FORWARDING_MODE_SELECT);
    endproperty
    a_publish_cause: assert property (p_publish_cause) else $error("published without cause");

    property p_idle_reload;
        idle_now && RELOAD_FRAME |=> SPLIT_STATE == tx_buffer_pkg::HOLD_STATE;
    endproperty
    a_idle_reload: assert property (p_idle_reload) else $error("idle reload not to hold");

    property p_idle_pause;
        idle_now && !RELOAD_FRAME && PAUSE_FRAME_GRANT |=> SPLIT_STATE == tx_buffer_pkg::PAUSE_FRAME_READ_STATE;
    endproperty
    a_idle_pause: assert property (p_idle_pause) else $error("idle pause");

    property p_discard_pause;
        SPLIT_STATE == tx_buffer_pkg::DISCARD_STATE && PAUSE_FRAME_GRANT
            |=> SPLIT_STATE == tx_buffer_pkg::PAUSE_FRAME_READ_STATE;
    endproperty
    a_discard_pause: assert property (p_discard_pause) else $error("discard pause");

    property p_hold_exit;
        SPLIT_STATE == tx_buffer_pkg::HOLD_STATE && !RELOAD_FRAME |=> SPLIT_STATE == tx_buffer_pkg::DISCARD_STATE;
    endproperty
    a_hold_exit: assert property (p_hold_exit) else $error("hold exit");
endmodule

`default_nettype wire

// [verif/tx_buffer_write_and_split_control_bench.sv]
`timescale 1ns/10ps
`default_nettype none

module tx_buffer_write_and_split_control_bench;
    // ------------------------------------------------------------
    // control masks {pause, payload, reload, remove, next, end, valid, start, unlock}
    // ------------------------------------------------------------
    localparam logic [8:0]  PG = 9'h100, DG = 9'h080, RL = 9'h040, RM = 9'h020, NX = 9'h010;
    localparam logic [8:0]  EN = 9'h008, VD = 9'h004, ST = 9'h002, UL = 9'h001, NO = 9'h000;
    localparam logic [4:0]  ID = tx_buffer_pkg::IDLE_STATE, PL = tx_buffer_pkg::PAYLOAD_READ_STATE;
    localparam logic [4:0]  PR = tx_buffer_pkg::PAUSE_FRAME_READ_STATE, DC = tx_buffer_pkg::DISCARD_STATE;
    localparam logic [4:0]  HO = tx_buffer_pkg::HOLD_STATE;
    localparam logic [31:0] WORD_BASE = 32'hA500_0000;

    logic clk, rst_n, mode, flag;
    logic [8:0] ctl;
    logic [5:0] level;
    logic [6:0] rd_addr;
    logic [7:0] add;
    wire logic empty, rd_en, wr_en, full;
    wire logic [31:0] fdata, wdata;
    wire logic [6:0] ptr, pub;
    wire logic [4:0] state;
    int num_errors, checks_done, writes;

    input_fifo_model #(.WORD_BASE(WORD_BASE)) partner (.clk(clk), .rst_n(rst_n), .read_enable(rd_en),
        .add_words(add), .empty(empty), .data(fdata));

    tx_buffer_write_and_split_control dut (.FREE_TX_CLOCK(clk), .GLOBAL_RESET_N(rst_n),
        .INPUT_FIFO_EMPTY(empty), .INPUT_FIFO_DATA(fdata), .INPUT_FIFO_READ_ENABLE(rd_en),
        .MEMORY_WRITE_ENABLE(wr_en), .MEMORY_WRITE_DATA(wdata), .MEMORY_WRITE_POINTER(ptr),
        .PUBLISHED_WRITE_ADDRESS(pub), .MEMORY_FULL(full), .MEMORY_READ_ADDRESS(rd_addr),
        .FORWARDING_MODE_SELECT(mode), .CUT_THROUGH_LEVEL(level), .FRAME_STORED_FLAG(flag),
        .PAUSE_FRAME_GRANT(ctl[8]), .PAYLOAD_FRAME_GRANT(ctl[7]), .RELOAD_FRAME(ctl[6]),
        .REMOVE_FRAME(ctl[5]), .NEXT_WORD_REQUEST(ctl[4]), .FRAME_END_OUT(ctl[3]),
        .VALID_DATA(ctl[2]), .FRAME_START_IN(ctl[1]), .UNLOCK_START(ctl[0]), .SPLIT_STATE(state));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task final_report;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // inputs change 1 ns after the edge
    task tick;
        @(posedge clk);
        #1;
    endtask

    task step(input logic [8:0] drive, input logic [4:0] expect_state);
        ctl = drive;
        tick;
        check("split state", state, expect_state);
    endtask

    task feed(input logic [7:0] n);
        add = n;
        tick;
        add = 8'h00;
    endtask

    // bounded wait, then check no overshoot
    task wait_ptr(input logic [6:0] target);
        int n;
        n = 0;
        while (ptr !== target && n < 300) begin
            tick;
            n++;
        end
        repeat (3) tick;
        check("write pointer", ptr, target);
    endtask

    // each write: next word at next location
    always @(negedge clk) begin
        if (rst_n === 1'b1 && wr_en === 1'b1) begin
            check("write data", wdata, WORD_BASE + writes);
            check("write location", ptr, writes[6:0]);
            writes++;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0; ctl = NO; mode = tx_buffer_pkg::STORE_FORWARD; flag = 1'b0;
        level = 6'h00; rd_addr = 7'h00; add = 8'h00;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        tick;
        check("reset state", state, ID);
        check("reset pointer", {pub, ptr, rd_en}, 15'h0000);
        // splitter walk, priorities at idle and discard exits (pause over reload in discard)
        step(RL | PG, HO);
        step(RL, HO);
        step(NO, DC);
        step(PG | RL, PR);
        step(EN | NX, DC);
        step(RL, HO);
        step(NO, DC);
        step(VD | ST | UL, ID);
        step(PG | DG, PR);
        step(RL, DC);
        step(VD | UL, HO);
        step(NO, DC);
        step(VD | ST | UL, ID);
        step(DG, PL);
        step(EN | NX, HO);
        step(NO, DC);
        step(VD | ST | UL, ID);
        step(DG, PL);
        step(RM, HO);
        step(NO, DC);
        step(VD | ST | UL, ID);
        step(NO, ID);
        // store-and-forward: nothing published early
        feed(8'h05);
        wait_ptr(7'h05);
        check("published store-forward", pub, 7'h00);
        flag = 1'b1;
        tick;
        flag = 1'b0;
        check("published on stored frame", pub, 7'h05);
        // cut-through: count must exceed the level
        mode = ~tx_buffer_pkg::STORE_FORWARD;
        level = 6'h05;
        feed(8'h05);
        wait_ptr(7'h0A);
        check("published at level", pub, 7'h05);
        feed(8'h01);
        wait_ptr(7'h0B);
        check("published above level", pub, 7'h0B);
        // fill memory, then free space twice
        feed(8'h46);
        wait_ptr(7'h40);
        check("full flag", full, 1'b1);
        check("reads stop when staged", {rd_en, empty}, 2'h0);
        rd_addr = 7'h08;
        wait_ptr(7'h48);
        check("full again", full, 1'b1);
        rd_addr = 7'h40;
        wait_ptr(7'h51);
        check("input fifo drained", empty, 1'b1);
        // reset acts between edges, no clock needed
        ctl = PG;
        tick;
        #1 rst_n = 1'b0;
        #1;
        check("async reset state", state, ID);
        check("async reset pointers", {pub, ptr}, 14'h0000);
        ctl = NO;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        tick;
        check("state after release", state, ID);
        final_report;
    end
endmodule

bind tx_buffer_write_and_split_control tx_buffer_write_and_split_control_properties chk (.FREE_TX_CLOCK,
    .GLOBAL_RESET_N, .INPUT_FIFO_EMPTY, .INPUT_FIFO_READ_ENABLE, .MEMORY_WRITE_ENABLE, .MEMORY_WRITE_POINTER,
    .PUBLISHED_WRITE_ADDRESS, .MEMORY_READ_ADDRESS, .FORWARDING_MODE_SELECT, .FRAME_STORED_FLAG,
    .PAUSE_FRAME_GRANT, .RELOAD_FRAME, .SPLIT_STATE);

`default_nettype wire
